// ### bench/ars_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "ars_map.svh"
module ars_mem_model (
  input wire logic i_clk, // processor clock
  input wire logic i_store, // write-back pulse
  input wire logic [`ARS_WORD-1:0] i_wdata, // write-back word
  output logic o_load_d, // term load strobe
  output logic [`ARS_WORD-1:0] o_operand // word from core or console
);
  logic [`ARS_WORD-1:0] last_wr; // last word written to core
  int wr_cnt; // write-backs seen
  // idle values at time zero
  initial begin
    o_load_d = 1'b0;
    o_operand = '0;
    last_wr = '0;
    wr_cnt = 0;
  end
  // one word to the term register, then a scrambled released line
  task automatic fetch(input logic [`ARS_WORD-1:0] w);
    @(posedge i_clk);
    #1;
    o_load_d = 1'b1;
    o_operand = w;
    @(posedge i_clk);
    #1;
    o_load_d = 1'b0;
    o_operand = ~w;
  endtask : fetch
  // core side takes results written back
  always @(posedge i_clk) begin
    if (i_store === 1'b1) begin
      last_wr <= i_wdata;
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule : ars_mem_model
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ars_map.svh"
module tb_top;
  logic i_clk, i_srst, i_start, i_abs, i_fp, i_store, load_d;
  ars_pkg::ars_op_t i_op;
  logic [6:0] i_shamt;
  logic [47:0] operand, o_acc, o_mq, o_din, o_wdata, acc1;
  logic o_busy, o_done, o_store, o_lt, o_eq, o_gt, o_ovf;
  logic signed [95:0] p;
  int miscompares, checks, cyc, i;
  ars_datapath dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_load_d(load_d), .i_operand(operand),
    .i_start(i_start), .i_op(i_op), .i_abs(i_abs), .i_fp(i_fp), .i_store(i_store),
    .i_shamt(i_shamt), .o_acc(o_acc), .o_mq(o_mq), .o_din(o_din), .o_busy(o_busy),
    .o_done(o_done), .o_store(o_store), .o_wdata(o_wdata), .o_lt(o_lt), .o_eq(o_eq),
    .o_gt(o_gt), .o_ovf(o_ovf));
  ars_mem_model mem_u (.i_clk(i_clk), .i_store(o_store), .i_wdata(o_wdata),
    .o_load_d(load_d), .o_operand(operand));
  // free-running processor clock
  always #12.5 i_clk = ~i_clk;
  task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("miscompares %0d checks %0d", miscompares, checks);
    if (miscompares == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // issue one operation and wait for its completion pulse
  task automatic do_op(input ars_pkg::ars_op_t op, input logic ab, input logic fp,
      input logic st, input logic [6:0] sh);
    int n;
    @(posedge i_clk);
    #1;
    i_start = 1'b1;
    i_op = op;
    i_abs = ab;
    i_fp = fp;
    i_store = st;
    i_shamt = sh;
    @(posedge i_clk);
    #1;
    i_start = 1'b0;
    acc1 = o_acc;
    chk("busy", o_busy, 1'b1);
    for (n = 0; n < 300 && o_done !== 1'b1; n++) begin
      @(posedge i_clk);
      #1;
    end
    cyc = n;
    if (n == 300) begin
      miscompares++;
      end_of_test();
    end
    chk("store", o_store, st);
  endtask : do_op
  // set the pair, leaving the term register at a
  task automatic ld(input logic [47:0] a, input logic [47:0] q);
    mem_u.fetch(q);
    do_op(ars_pkg::OP_LDQ, 1'b0, 1'b0, 1'b0, 7'h00);
    mem_u.fetch(a);
    do_op(ars_pkg::OP_LDA, 1'b0, 1'b0, 1'b0, 7'h00);
  endtask : ld
  task automatic t_reset();
    i_srst = 1'b1;
    repeat (4) @(posedge i_clk);
    #1;
    i_srst = 1'b0;
    chk("rst", {o_acc, o_mq}, '0);
    chk("rst_din", {o_din, o_busy, o_done, o_store, o_lt, o_eq, o_gt, o_ovf}, '0);
  endtask : t_reset
  task automatic t_add_sub();
    ld(48'hFFFF_FFFF_FFFF, 48'h0);
    mem_u.fetch(48'h2);
    do_op(ars_pkg::OP_ADD, 1'b0, 1'b0, 1'b0, 7'h00);
    chk("add_early", acc1, 48'h1);
    chk("add_cyc", cyc, 40);
    ld(48'h5, 48'h0);
    mem_u.fetch(48'h7);
    fork
      do_op(ars_pkg::OP_SUB, 1'b0, 1'b0, 1'b0, 7'h00);
      begin
        repeat (4) @(posedge i_clk);
        mem_u.fetch(48'hABC);
      end
    join
    chk("sub", o_acc, 48'hFFFF_FFFF_FFFE);
    chk("sub_refused_load", o_din, 48'h7);
  endtask : t_add_sub
  task automatic t_cmp();
    logic [47:0] dv [3];
    dv = '{48'h7, 48'h5, 48'h3};
    for (i = 0; i < 3; i++) begin
      ld(48'h5, 48'h0);
      mem_u.fetch(dv[i]);
      do_op(ars_pkg::OP_CMP, 1'b0, 1'b0, 1'b0, 7'h00);
      chk("cmp_flags", {o_lt, o_eq, o_gt}, 3'b100 >> i);
      chk("cmp_keep", o_acc, 48'h5);
    end
  endtask : t_cmp
  task automatic t_fp();
    for (i = 0; i < 2; i++) begin
      ld(48'h000F_FFFF_FFFF, 48'h0);
      mem_u.fetch(48'h1);
      do_op(ars_pkg::OP_ADD, 1'b0, i[0], 1'b0, 7'h00);
      chk("split", o_acc, (i == 1) ? 48'h0 : 48'h0010_0000_0000);
      ld(48'h0010_0000_0000, 48'h0);
      mem_u.fetch(48'h1);
      do_op(ars_pkg::OP_SUB, 1'b0, i[0], 1'b0, 7'h00);
      chk("split_sub", o_acc, (i == 1) ? 48'h001F_FFFF_FFFF : 48'h000F_FFFF_FFFF);
    end
  endtask : t_fp
  task automatic t_shift();
    ld(48'hF0F0_F0F0_F0F0, 48'h0);
    mem_u.fetch(48'hFF00_FF00_FF00);
    do_op(ars_pkg::OP_EXT, 1'b0, 1'b0, 1'b0, 7'h00);
    chk("ext", o_acc, 48'hF000_F000_F000);
    ld(48'h0, 48'h8000_0000_0001);
    do_op(ars_pkg::OP_SHL, 1'b0, 1'b0, 1'b0, 7'h01);
    chk("shl", {o_acc, o_mq}, {48'h1, 48'h2});
    chk("shl_cyc", cyc, 40);
    ld(48'h8000_0000_0000, 48'h0);
    do_op(ars_pkg::OP_SHR, 1'b0, 1'b0, 1'b0, 7'h32);
    p = {48'h8000_0000_0000, 48'h0};
    p = p >>> 50;
    chk("shr", {o_acc, o_mq}, p);
    chk("shr_cyc", cyc, 51);
  endtask : t_shift
  task automatic t_mul();
    ld(48'h0, 48'hFFFF_FFFF_FFFD);
    mem_u.fetch(48'h7);
    do_op(ars_pkg::OP_MUL, 1'b0, 1'b0, 1'b0, 7'h00);
    chk("mul", {o_acc, o_mq}, {48'hFFFF_FFFF_FFFF, 48'hFFFF_FFFF_FFEB});
    chk("mul_cyc", cyc, 50);
    ld(48'h0, 48'hFFFF_FFFF_FFFD);
    mem_u.fetch(48'h7);
    do_op(ars_pkg::OP_MUL, 1'b1, 1'b0, 1'b0, 7'h00);
    chk("mul_abs", {o_acc, o_mq}, {48'h0, 48'h15});
    ld(48'h0, 48'h4000_0000_0000);
    mem_u.fetch(48'h3);
    do_op(ars_pkg::OP_MRND, 1'b0, 1'b0, 1'b0, 7'h00);
    chk("mrnd", {o_acc, o_mq}, {48'h1, 48'h0});
    for (i = 0; i < 2; i++) begin
      ld(48'hA, 48'h4000_0000_0000);
      mem_u.fetch(48'h3);
      do_op(i ? ars_pkg::OP_MSUB : ars_pkg::OP_MADD, 1'b0, 1'b0, 1'b0, 7'h00);
      chk("fused", o_acc, i ? 48'hFFFF_FFFF_FFF7 : 48'hB);
      chk("fused_cyc", cyc, 52);
    end
  endtask : t_mul
  task automatic t_div();
    ld(48'h0, 48'h64);
    mem_u.fetch(48'h7);
    do_op(ars_pkg::OP_DIV, 1'b0, 1'b0, 1'b0, 7'h00);
    chk("div", {o_acc, o_mq, o_ovf}, {48'h2, 48'hE, 1'b0});
    chk("div_cyc", cyc, 51);
    ld(48'h8, 48'h0);
    mem_u.fetch(48'h3);
    do_op(ars_pkg::OP_DIV, 1'b0, 1'b0, 1'b0, 7'h00);
    chk("div_ovf", {o_ovf, cyc[7:0]}, {1'b1, 8'h35});
    ld(48'h3, 48'h4);
    mem_u.fetch(48'h0);
    do_op(ars_pkg::OP_DIV, 1'b0, 1'b0, 1'b0, 7'h00);
    chk("div_zero", {o_acc, o_mq, o_ovf}, {48'h3, 48'h4, 1'b1});
    chk("div_zero_cyc", cyc, 40);
  endtask : t_div
  task automatic t_abs_store();
    ld(48'hFFFF_FFFF_FFFB, 48'h0);
    mem_u.fetch(48'hFFFF_FFFF_FFFD);
    do_op(ars_pkg::OP_ADD, 1'b1, 1'b0, 1'b1, 7'h00);
    chk("abs", o_acc, 48'h8);
    chk("wdata", o_wdata, 48'h8);
    @(posedge i_clk);
    #1;
    chk("written", {mem_u.last_wr, mem_u.wr_cnt[7:0]}, {48'h8, 8'h01});
    chk("store_pulse", o_store, 1'b0);
  endtask : t_abs_store
  // main sequence, ending with a reset in mid-operation
  initial begin
    i_clk = 1'b0;
    i_srst = 1'b1;
    i_start = 1'b0;
    i_op = ars_pkg::OP_ADD;
    {i_abs, i_fp, i_store, i_shamt} = '0;
    miscompares = 0;
    checks = 0;
    t_reset();
    t_add_sub();
    t_cmp();
    t_fp();
    t_shift();
    t_mul();
    t_div();
    t_abs_store();
    ld(48'h9, 48'h9);
    #1;
    i_start = 1'b1;
    i_op = ars_pkg::OP_MUL;
    repeat (3) @(posedge i_clk);
    #1;
    i_start = 1'b0;
    t_reset();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// ### hw/ars_adder.sv
`timescale 1ns/100ps
`default_nettype none
module ars_adder #(
  parameter int W = 48,
  parameter int MW = 36
) (
  input wire logic [W-1:0] i_a, // first term
  input wire logic [W-1:0] i_b, // second term
  input wire logic i_cin, // carry in
  input wire logic i_split, // mantissa/exponent split
  output logic [W-1:0] o_sum, // sum
  output logic o_cout // carry out
);
  logic [MW:0] lo;
  logic [W-MW:0] hi;
  logic hi_cin;

  // pure combinational parallel binary adder, all bits at once
  always_comb begin
    lo = {1'b0, i_a[MW-1:0]} + {1'b0, i_b[MW-1:0]} + {{MW{1'b0}}, i_cin}; // see RQ3
    hi_cin = i_split ? i_cin : lo[MW]; // see RQ5
    hi = {1'b0, i_a[W-1:MW]} + {1'b0, i_b[W-1:MW]} + {{(W-MW){1'b0}}, hi_cin};
    o_sum = {hi[W-MW-1:0], lo[MW-1:0]};
    o_cout = hi[W-MW];
  end
endmodule : ars_adder
`default_nettype wire

// ### hw/ars_datapath.sv
`timescale 1ns/100ps
`default_nettype none
`include "ars_map.svh"
// Summary of operation
// RQ1: sum holder, low product, incoming term registers
// RQ2: shifts/extract in registers; arithmetic through adder
// RQ3: adder combinational, all 48 bits binary
// RQ4: subtract adds two's complement of term
// RQ5: floating option splits adder mantissa/exponent
// RQ6: multiply gives double or rounded product
// RQ7: double-length divide, self-corrects on overflow
// RQ8: fused multiply-add and multiply-subtract
// RQ9: optional absolute operands, optional memory write-back
// RQ10: transfer and fastest add take one microsecond
// RQ11: term loaded from memory or console
// RQ12: sums to holder; pair forms 96-bit double
// RQ13: compare subtracts, holder kept, sign reported
module ars_datapath #(
  parameter int W = `ARS_WORD,
  parameter int MW = `ARS_MANT,
  parameter int SHW = `ARS_SHW,
  parameter int XFER_CYC = `ARS_XFER_CYC
) (
  input wire logic i_clk, // processor clock
  input wire logic i_srst, // sync reset, high
  input wire logic i_load_d, // load incoming term
  input wire logic [W-1:0] i_operand, // word from memory or console
  input wire logic i_start, // start operation
  input wire ars_pkg::ars_op_t i_op, // operation code
  input wire logic i_abs, // absolute-value operands
  input wire logic i_fp, // floating split of adder
  input wire logic i_store, // write result back
  input wire logic [SHW-1:0] i_shamt, // shift count
  output logic [W-1:0] o_acc, // sum holder
  output logic [W-1:0] o_mq, // low product register
  output logic [W-1:0] o_din, // incoming term register
  output logic o_busy, // operation in progress
  output logic o_done, // completion pulse
  output logic o_store, // write-back pulse
  output logic [W-1:0] o_wdata, // write-back word
  output logic o_lt, // compare: less
  output logic o_eq, // compare: equal
  output logic o_gt, // compare: greater
  output logic o_ovf // divide overflow corrected, or zero divisor
);
  localparam int W2 = 2 * W;
  localparam int STW = $clog2(W);
  localparam int CW = `ARS_CNTW;
  localparam int EW = W - MW;

  logic [W-1:0] acc_ff, nxt_acc, mq_ff, nxt_mq, din_ff, nxt_din, add_ff, nxt_add;
  logic [W-1:0] wdata_ff, nxt_wdata, opa, opd, dmag;
  ars_pkg::ars_state_t st_ff, nxt_st;
  ars_pkg::ars_op_t op_ff, nxt_op;
  logic abs_ff, nxt_abs, store_ff, nxt_store, neg_ff, nxt_neg, rneg_ff, nxt_rneg;
  logic busy_ff, nxt_busy, done_ff, nxt_done, wr_ff, nxt_wr;
  logic lt_ff, nxt_lt, eq_ff, nxt_eq, gt_ff, nxt_gt, ovf_ff, nxt_ovf;
  logic [SHW-1:0] sh_ff, nxt_sh;
  logic [STW-1:0] step_ff, nxt_step;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic [W-1:0] add_a, add_b, add_sum;
  logic add_cin, add_split, add_cout, sub_op, cmp_ov, qbit;
  logic [W2-1:0] pair;

  // two's complement magnitude of a word
  function automatic logic [W-1:0] mag(input logic [W-1:0] x);
    mag = x[W-1] ? W'(~x + 1'b1) : x;
  endfunction : mag

  // two's complement negation of a double word
  function automatic logic [W2-1:0] neg2(input logic [W2-1:0] x);
    neg2 = W2'(~x + 1'b1);
  endfunction : neg2

  ars_adder #(.W(W), .MW(MW)) u_adder (
    .i_a(add_a),
    .i_b(add_b),
    .i_cin(add_cin),
    .i_split(add_split),
    .o_sum(add_sum),
    .o_cout(add_cout)
  );

  // operand selection at issue time
  assign opa = i_abs ? mag(acc_ff) : acc_ff; // see RQ9
  assign opd = i_abs ? mag(din_ff) : din_ff;
  assign dmag = mag(din_ff);
  assign sub_op = (i_op == ars_pkg::OP_SUB) || (i_op == ars_pkg::OP_CMP);
  assign cmp_ov = (opa[W-1] ^ opd[W-1]) & (add_sum[W-1] ^ opa[W-1]);
  assign pair = {acc_ff, mq_ff};
  assign qbit = acc_ff[W-1] | add_cout;

  // adder operand steering per state
  always_comb begin
    add_a = '0;
    add_b = '0;
    add_cin = 1'b0;
    add_split = 1'b0;
    case (st_ff)
      ars_pkg::ST_IDLE: begin
        add_a = opa;
        add_b = sub_op ? ~opd : opd; // see RQ4
        add_cin = sub_op;
        add_split = i_fp; // see RQ5
      end
      ars_pkg::ST_MUL: begin
        add_a = acc_ff;
        add_b = mq_ff[0] ? dmag : '0; // see RQ2
      end
      ars_pkg::ST_DCHK: begin
        add_a = acc_ff;
        add_b = ~dmag;
        add_cin = 1'b1;
      end
      ars_pkg::ST_DIV: begin
        add_a = {acc_ff[W-2:0], mq_ff[W-1]};
        add_b = ~dmag;
        add_cin = 1'b1;
      end
      ars_pkg::ST_RND: begin
        add_a = acc_ff;
        add_cin = mq_ff[W-1]; // see RQ6
      end
      ars_pkg::ST_FUSE: begin
        add_a = acc_ff;
        add_b = (op_ff == ars_pkg::OP_MSUB) ? ~add_ff : add_ff; // see RQ8
        add_cin = (op_ff == ars_pkg::OP_MSUB);
      end
      default: begin
        add_a = '0;
      end
    endcase
  end

  // sequencer and register next values
  always_comb begin
    nxt_acc = acc_ff;
    nxt_mq = mq_ff;
    nxt_din = din_ff;
    nxt_add = add_ff;
    nxt_wdata = wdata_ff;
    nxt_st = st_ff;
    nxt_op = op_ff;
    nxt_abs = abs_ff;
    nxt_store = store_ff;
    nxt_neg = neg_ff;
    nxt_rneg = rneg_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_wr = 1'b0;
    nxt_lt = lt_ff;
    nxt_eq = eq_ff;
    nxt_gt = gt_ff;
    nxt_ovf = ovf_ff;
    nxt_sh = sh_ff;
    nxt_step = step_ff;
    nxt_cnt = (cnt_ff == '1) ? cnt_ff : CW'(cnt_ff + 1'b1);
    case (st_ff)
      ars_pkg::ST_IDLE: begin
        nxt_cnt = '0;
        if (i_load_d) begin
          nxt_din = i_operand; // see RQ11
        end
        if (i_start) begin
          nxt_op = i_op;
          nxt_abs = i_abs;
          nxt_store = i_store;
          nxt_busy = 1'b1;
          nxt_cnt = CW'(1);
          nxt_st = ars_pkg::ST_WAIT;
          case (i_op)
            ars_pkg::OP_ADD, ars_pkg::OP_SUB: nxt_acc = add_sum; // see RQ12
            ars_pkg::OP_CMP: begin
              nxt_lt = add_sum[W-1] ^ cmp_ov; // see RQ13
              nxt_eq = (add_sum == '0);
              nxt_gt = ~(add_sum[W-1] ^ cmp_ov) & (add_sum != '0);
            end
            ars_pkg::OP_LDA: nxt_acc = din_ff;
            ars_pkg::OP_LDQ: nxt_mq = din_ff;
            ars_pkg::OP_EXT: nxt_acc = acc_ff & din_ff; // see RQ2
            ars_pkg::OP_SHL, ars_pkg::OP_SHR: nxt_sh = i_shamt;
            ars_pkg::OP_DIV: begin
              nxt_neg = ~i_abs & (acc_ff[W-1] ^ din_ff[W-1]);
              nxt_rneg = ~i_abs & acc_ff[W-1];
              {nxt_acc, nxt_mq} = acc_ff[W-1] ? neg2(pair) : pair; // see RQ7
              nxt_ovf = (dmag == '0);
              nxt_st = (dmag == '0) ? ars_pkg::ST_WAIT : ars_pkg::ST_DCHK;
            end
            default: begin
              nxt_add = opa;
              nxt_neg = ~i_abs & (mq_ff[W-1] ^ din_ff[W-1]);
              nxt_acc = '0;
              nxt_mq = mag(mq_ff);
              nxt_step = '0;
              nxt_st = ars_pkg::ST_MUL;
            end
          endcase
        end
      end
      ars_pkg::ST_MUL: begin
        {nxt_acc, nxt_mq} = {add_cout, add_sum, mq_ff[W-1:1]};
        nxt_step = STW'(step_ff + 1'b1);
        if (step_ff == STW'(W - 1)) begin
          nxt_st = ars_pkg::ST_FIX;
        end
      end
      ars_pkg::ST_DCHK: begin
        if (add_cout) begin
          {nxt_acc, nxt_mq} = {1'b0, pair[W2-1:1]}; // see RQ7
          nxt_ovf = 1'b1;
        end else begin
          nxt_step = '0;
          nxt_st = ars_pkg::ST_DIV;
        end
      end
      ars_pkg::ST_DIV: begin
        nxt_acc = qbit ? add_sum : add_a;
        nxt_mq = {mq_ff[W-2:0], qbit};
        nxt_step = STW'(step_ff + 1'b1);
        if (step_ff == STW'(W - 1)) begin
          nxt_st = ars_pkg::ST_FIX;
        end
      end
      ars_pkg::ST_FIX: begin
        nxt_st = ars_pkg::ST_WAIT;
        if (op_ff == ars_pkg::OP_DIV) begin
          nxt_mq = neg_ff ? W'(~mq_ff + 1'b1) : mq_ff;
          nxt_acc = rneg_ff ? W'(~acc_ff + 1'b1) : acc_ff;
        end else begin
          {nxt_acc, nxt_mq} = neg_ff ? neg2(pair) : pair; // see RQ12
          if (op_ff != ars_pkg::OP_MUL) begin
            nxt_st = ars_pkg::ST_RND;
          end
        end
      end
      ars_pkg::ST_RND: begin
        nxt_acc = add_sum;
        nxt_mq = '0;
        nxt_st = (op_ff == ars_pkg::OP_MRND) ? ars_pkg::ST_WAIT : ars_pkg::ST_FUSE;
      end
      ars_pkg::ST_FUSE: begin
        nxt_acc = add_sum;
        nxt_st = ars_pkg::ST_WAIT;
      end
      ars_pkg::ST_WAIT: begin
        if (sh_ff != '0) begin
          nxt_sh = SHW'(sh_ff - 1'b1);
          if (op_ff == ars_pkg::OP_SHL) begin
            {nxt_acc, nxt_mq} = {pair[W2-2:0], 1'b0};
          end else begin
            {nxt_acc, nxt_mq} = {acc_ff[W-1], pair[W2-1:1]};
          end
        end else if (cnt_ff >= CW'(XFER_CYC)) begin
          nxt_done = 1'b1; // see RQ10
          nxt_wr = store_ff; // see RQ9
          nxt_wdata = acc_ff;
          nxt_busy = 1'b0;
          nxt_st = ars_pkg::ST_IDLE;
        end
      end
      default: nxt_st = ars_pkg::ST_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      acc_ff <= '0; // see RQ1
      mq_ff <= '0;
      din_ff <= '0;
      add_ff <= '0;
      wdata_ff <= '0;
      st_ff <= ars_pkg::ST_IDLE;
      op_ff <= ars_pkg::OP_ADD;
      {abs_ff, store_ff, neg_ff, rneg_ff, busy_ff, done_ff, wr_ff} <= '0;
      {lt_ff, eq_ff, gt_ff, ovf_ff} <= '0;
      sh_ff <= '0;
      step_ff <= '0;
      cnt_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
      mq_ff <= nxt_mq;
      din_ff <= nxt_din;
      add_ff <= nxt_add;
      wdata_ff <= nxt_wdata;
      st_ff <= nxt_st;
      op_ff <= nxt_op;
      {abs_ff, store_ff, neg_ff, rneg_ff} <= {nxt_abs, nxt_store, nxt_neg, nxt_rneg};
      {busy_ff, done_ff, wr_ff} <= {nxt_busy, nxt_done, nxt_wr};
      {lt_ff, eq_ff, gt_ff, ovf_ff} <= {nxt_lt, nxt_eq, nxt_gt, nxt_ovf};
      sh_ff <= nxt_sh;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
    end
  end

  // outputs straight from flip-flops
  assign o_acc = acc_ff;
  assign o_mq = mq_ff;
  assign o_din = din_ff;
  assign o_busy = busy_ff;
  assign o_done = done_ff;
  assign o_store = wr_ff;
  assign o_wdata = wdata_ff;
  assign {o_lt, o_eq, o_gt, o_ovf} = {lt_ff, eq_ff, gt_ff, ovf_ff};

  // checking helpers: expected product, divisor, busy run length
  logic [W2-1:0] exp_ff, nxt_exp;
  logic [W-1:0] dexp_ff, nxt_dexp;
  logic [CW-1:0] run_ff, nxt_run;
  logic issue;
  assign issue = (st_ff == ars_pkg::ST_IDLE) && i_start;
  always_comb begin
    nxt_exp = issue ? W2'($signed({{W{mq_ff[W-1]}}, mq_ff}) * $signed({{W{din_ff[W-1]}}, din_ff}))
                    : exp_ff;
    nxt_dexp = issue ? dmag : dexp_ff;
    nxt_run = busy_ff ? ((run_ff == '1) ? run_ff : CW'(run_ff + 1'b1)) : '0;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      exp_ff <= '0;
      dexp_ff <= '0;
      run_ff <= '0;
    end else begin
      exp_ff <= nxt_exp;
      dexp_ff <= nxt_dexp;
      run_ff <= nxt_run;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  add_result_a: assert property (issue && i_op == ars_pkg::OP_ADD && !i_abs && !i_fp |=> // see RQ3
    o_acc == W'($past(o_acc) + $past(o_din))) else $error("add result wrong");
  sub_result_a: assert property (issue && i_op == ars_pkg::OP_SUB && !i_abs && !i_fp |=> // see RQ4
    o_acc == W'($past(o_acc) - $past(o_din))) else $error("subtract result wrong");
  split_exp_a: assert property (issue && i_op == ars_pkg::OP_ADD && !i_abs && i_fp |=> // see RQ5
    o_acc[W-1:MW] == EW'($past(o_acc[W-1:MW]) + $past(o_din[W-1:MW])))
    else $error("exponent half not independent");
  cmp_keeps_acc_a: assert property (issue && i_op == ars_pkg::OP_CMP && !i_abs |=> // see RQ13
    $stable(o_acc) && o_lt == ($signed($past(o_acc)) < $signed($past(o_din)))
    && o_eq == ($past(o_acc) == $past(o_din))) else $error("compare flags or holder wrong");
  mul_double_a: assert property (o_done && op_ff == ars_pkg::OP_MUL && !abs_ff |-> // see RQ6
    {o_acc, o_mq} == exp_ff) else $error("double product wrong");
  div_remainder_a: assert property (o_done && op_ff == ars_pkg::OP_DIV && !o_ovf |-> // see RQ7
    mag(o_acc) < dexp_ff) else $error("remainder not below divisor");
  min_time_a: assert property ($fell(o_busy) |-> o_done && run_ff >= CW'(XFER_CYC)) // see RQ10
    else $error("operation shorter than transfer time");
  store_pulse_a: assert property (o_done && store_ff |-> o_store && o_wdata == o_acc) // see RQ9
    else $error("write-back missing");
  extract_a: assert property (issue && i_op == ars_pkg::OP_EXT |=> // see RQ2
    o_acc == ($past(o_acc) & $past(o_din)) ##1 $stable(o_acc)) else $error("extract wrong");
endmodule : ars_datapath
`default_nettype wire

// ### inc/ars_map.svh
`ifndef ARS_MAP_SVH
`define ARS_MAP_SVH
// word and field widths
`define ARS_WORD 48
`define ARS_MANT 36
`define ARS_SHW 7
`define ARS_CNTW 8
// timing: clock period and basic transfer time in ns
`define ARS_CLK_NS 25
`define ARS_XFER_NS 1000
`define ARS_XFER_CYC ((`ARS_XFER_NS + `ARS_CLK_NS - 1) / `ARS_CLK_NS)
`endif

// ### inc/ars_pkg.sv
package ars_pkg;
  // operation codes presented with the start strobe
  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_CMP = 4'h2,
    OP_LDA = 4'h3,
    OP_LDQ = 4'h4,
    OP_EXT = 4'h5,
    OP_SHL = 4'h6,
    OP_SHR = 4'h7,
    OP_MUL = 4'h8,
    OP_MRND = 4'h9,
    OP_MADD = 4'hA,
    OP_MSUB = 4'hB,
    OP_DIV = 4'hC
  } ars_op_t;
  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_WAIT = 8'h02,
    ST_MUL = 8'h04,
    ST_DCHK = 8'h08,
    ST_DIV = 8'h10,
    ST_FIX = 8'h20,
    ST_RND = 8'h40,
    ST_FUSE = 8'h80
  } ars_state_t;
endpackage : ars_pkg
